// ---- rtl/btfb_exec.sv ----
// bit-toggle and flag-branch execution unit with avalon-mm control registers
//
// Operation
// - the bit-toggle op is upper nibble 0111, then an 8-bit address, a 3-bit bit index and the access bit at bit 0.
// - bit-toggle inverts only the chosen bit of the addressed byte (0 to 255) and writes it back in place.
// - with the access bit at 0 the operand lies in the fixed access bank.
// - with the access bit at 1 the bank-select register supplies the bank, which is the default.
// - with extended mode on, access bit 0 and address at most 95, the operand is indexed off the index base.
// - bit-toggle never changes any status flag, even if the byte becomes zero.
// - branch-on-overflow is upper byte 1110 0100 with a signed 8-bit word offset below.
// - branch-on-overflow jumps only when the overflow flag is 1, else falls through.
// - branch-on-zero is upper byte 1110 0000 with a signed 8-bit word offset below.
// - branch-on-zero jumps only when the zero flag is 1, else falls through.
// - a taken branch loads the pc with instruction address plus 2 plus twice the offset.
// - a branch not taken takes one cycle, a taken one adds an idle cycle, and each is one word.
// - a branch not taken leaves the pc at instruction address plus 2.
`default_nettype none
`include "btfb_defs.svh"

module btfb_exec import btfb_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // instruction fetch
  output logic [20:0] fetch_addr,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  // core status flags
  input wire logic ovf_flag,
  input wire logic zero_flag,
  // data memory, read data one clock after mem_rd
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  btfb_phase_t phase;

  btfb_phase_gen u_phase (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .phase(phase)
  );

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic [3:0] bank_q;
  logic [3:0] bank_d;
  logic [11:0] index_q;
  logic [11:0] index_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic bus_wr;
  logic pc_wr;
  logic unsup_clr;

  btfb_op_t op_q;
  btfb_op_t op_d;
  btfb_op_t dec_op;
  logic [20:0] pc_q;
  logic [20:0] pc_d;
  logic [20:0] inst_addr_q;
  logic [20:0] inst_addr_d;
  logic [20:0] target_q;
  logic [20:0] target_d;
  logic [15:0] ir_q;
  logic [15:0] ir_d;
  logic [15:0] retire_q;
  logic [15:0] retire_d;
  logic busy_q;
  logic busy_d;
  logic idle_q;
  logic idle_d;
  logic taken_q;
  logic taken_d;
  logic unsup_q;
  logic unsup_d;
  logic [11:0] mem_addr_q;
  logic [11:0] mem_addr_d;
  logic mem_rd_q;
  logic mem_rd_d;
  logic mem_wr_q;
  logic mem_wr_d;
  logic [7:0] mem_wdata_q;
  logic [7:0] mem_wdata_d;

  logic run;
  logic ext_en;
  logic [7:0] f_field;
  logic [2:0] b_field;
  logic a_field;
  logic [11:0] eff_addr;
  logic [20:0] offset_x2;
  logic cond;

  assign run = ctrl_q[`BTFB_CTRL_RUN_BIT];
  assign ext_en = ctrl_q[`BTFB_CTRL_EXT_BIT];

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  // one wait state: the request is seen, then answered on the next edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;
  assign bus_wr = avs_write & ack_q;
  assign pc_wr = bus_wr & (avs_address == `BTFB_REG_PC) & ~run;
  assign unsup_clr = bus_wr & (avs_address == `BTFB_REG_STATUS) &
                     avs_byteenable[0] & avs_writedata[`BTFB_ST_UNSUP_BIT];

  always_comb begin
    logic [31:0] merged;
    merged = 32'h00000000;
    ack_d = (avs_read | avs_write) & ~ack_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    bank_d = bank_q;
    index_d = index_q;
    if (avs_read & ~ack_q) begin
      case (avs_address)
        `BTFB_REG_CTRL: rdata_d = {30'h00000000, ctrl_q};
        `BTFB_REG_STATUS: rdata_d = {28'h0000000, idle_q, unsup_q, taken_q, busy_q};
        `BTFB_REG_PC: rdata_d = {11'h000, pc_q};
        `BTFB_REG_BANK: rdata_d = {28'h0000000, bank_q};
        `BTFB_REG_INDEX: rdata_d = {20'h00000, index_q};
        `BTFB_REG_RETIRE: rdata_d = {16'h0000, retire_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (bus_wr) begin
      case (avs_address)
        `BTFB_REG_CTRL: begin
          merged = be_merge({30'h00000000, ctrl_q}, avs_writedata, avs_byteenable);
          ctrl_d = merged[1:0];
        end
        `BTFB_REG_BANK: begin
          merged = be_merge({28'h0000000, bank_q}, avs_writedata, avs_byteenable);
          bank_d = merged[3:0];
        end
        `BTFB_REG_INDEX: begin
          merged = be_merge({20'h00000, index_q}, avs_writedata, avs_byteenable);
          index_d = merged[11:0];
        end
        default: merged = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      ctrl_q <= `BTFB_CTRL_RST;
      bank_q <= `BTFB_BANK_RST;
      index_q <= `BTFB_INDEX_RST;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      bank_q <= bank_d;
      index_q <= index_d;
    end
  end

  // ----------------------------------------------------------------
  // decode and operand address
  // ----------------------------------------------------------------
  assign f_field = instr_word[11:4];
  assign b_field = ir_q[3:1];
  assign a_field = instr_word[0];

  always_comb begin
    if (instr_word[15:12] == `BTFB_OP_TOGGLE) begin
      dec_op = btfb_op_toggle;
    end else if (instr_word[15:8] == `BTFB_OP_BOV) begin
      dec_op = btfb_op_bov;
    end else if (instr_word[15:8] == `BTFB_OP_BZ) begin
      dec_op = btfb_op_bz;
    end else begin
      dec_op = btfb_op_none;
    end
  end

  always_comb begin
    if (a_field) begin
      eff_addr = {bank_q, f_field};
    end else if (ext_en && (f_field <= `BTFB_INDEX_MAX)) begin
      eff_addr = index_q + {4'h0, f_field};
    end else if (f_field < `BTFB_ACCESS_SPLIT) begin
      eff_addr = {`BTFB_ACCESS_LO_BANK, f_field};
    end else begin
      eff_addr = {`BTFB_ACCESS_HI_BANK, f_field};
    end
  end

  // word offset doubled and sign-extended to pc width
  assign offset_x2 = {{12{ir_q[7]}}, ir_q[7:0], 1'b0};
  assign cond = (op_q == btfb_op_bov) ? ovf_flag :
                (op_q == btfb_op_bz) ? zero_flag : 1'b0;

  // ----------------------------------------------------------------
  // execution sequence
  // ----------------------------------------------------------------
  assign instr_ready = run & (phase == btfb_q1) & ~idle_q;

  always_comb begin
    op_d = op_q;
    pc_d = pc_q;
    inst_addr_d = inst_addr_q;
    target_d = target_q;
    ir_d = ir_q;
    retire_d = retire_q;
    busy_d = busy_q;
    idle_d = idle_q;
    taken_d = taken_q;
    unsup_d = unsup_q & ~unsup_clr;
    mem_addr_d = mem_addr_q;
    mem_rd_d = 1'b0;
    mem_wr_d = 1'b0;
    mem_wdata_d = mem_wdata_q;
    case (phase)
      btfb_q1: begin
        if (!idle_q && instr_ready && instr_valid) begin
          ir_d = instr_word;
          op_d = dec_op;
          busy_d = 1'b1;
          taken_d = 1'b0;
          inst_addr_d = pc_q;
          pc_d = pc_q + `BTFB_PC_STEP;
          if (dec_op == btfb_op_toggle) begin
            mem_addr_d = eff_addr;
            mem_rd_d = 1'b1;
          end
          if (dec_op == btfb_op_none) begin
            unsup_d = 1'b1;
          end
        end
      end
      btfb_q2: begin
        // branch literal is already held in the instruction latch
        target_d = inst_addr_q + `BTFB_PC_STEP + offset_x2;
      end
      btfb_q3: begin
        if (op_q == btfb_op_toggle) begin
          // only the data byte is written, status flags are left alone
          mem_wdata_d = mem_rdata ^ (`BTFB_BIT_ONE << b_field);
          mem_wr_d = 1'b1;
        end
        if ((op_q == btfb_op_bov) || (op_q == btfb_op_bz)) begin
          taken_d = cond;
        end
      end
      btfb_q4: begin
        if (idle_q) begin
          idle_d = 1'b0;
        end
        if (busy_q) begin
          if (taken_q) begin
            pc_d = target_q;
            idle_d = 1'b1;
          end
          retire_d = retire_q + 16'h0001;
          busy_d = 1'b0;
          op_d = btfb_op_none;
        end
      end
      default: begin
        busy_d = 1'b0;
      end
    endcase
    if (pc_wr) begin
      pc_d = {avs_writedata[20:1], 1'b0};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      op_q <= btfb_op_none;
      pc_q <= `BTFB_PC_RST;
      inst_addr_q <= `BTFB_PC_RST;
      target_q <= `BTFB_PC_RST;
      ir_q <= 16'h0000;
      retire_q <= `BTFB_RETIRE_RST;
      busy_q <= 1'b0;
      idle_q <= 1'b0;
      taken_q <= 1'b0;
      unsup_q <= 1'b0;
      mem_addr_q <= 12'h000;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_wdata_q <= 8'h00;
    end else begin
      op_q <= op_d;
      pc_q <= pc_d;
      inst_addr_q <= inst_addr_d;
      target_q <= target_d;
      ir_q <= ir_d;
      retire_q <= retire_d;
      busy_q <= busy_d;
      idle_q <= idle_d;
      taken_q <= taken_d;
      unsup_q <= unsup_d;
      mem_addr_q <= mem_addr_d;
      mem_rd_q <= mem_rd_d;
      mem_wr_q <= mem_wr_d;
      mem_wdata_q <= mem_wdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign fetch_addr = pc_q;
  assign mem_addr = mem_addr_q;
  assign mem_rd = mem_rd_q;
  assign mem_wr = mem_wr_q;
  assign mem_wdata = mem_wdata_q;

endmodule

`default_nettype wire

// ---- rtl/btfb_defs.svh ----
// constants for the bit-toggle and flag-branch execution block
`ifndef BTFB_DEFS_SVH
`define BTFB_DEFS_SVH

// ----------------------------------------------------------------
// instruction encodings
// ----------------------------------------------------------------
`define BTFB_OP_TOGGLE 4'h7
`define BTFB_OP_BOV 8'he4
`define BTFB_OP_BZ 8'he0

// ----------------------------------------------------------------
// data addressing
// ----------------------------------------------------------------
`define BTFB_INDEX_MAX 8'h5f
`define BTFB_ACCESS_SPLIT 8'h60
`define BTFB_ACCESS_LO_BANK 4'h0
`define BTFB_ACCESS_HI_BANK 4'hf
`define BTFB_BIT_ONE 8'h01

// ----------------------------------------------------------------
// program counter
// ----------------------------------------------------------------
`define BTFB_PC_STEP 21'h000002
`define BTFB_PC_RST 21'h000000

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BTFB_REG_CTRL 5'h00
`define BTFB_REG_STATUS 5'h04
`define BTFB_REG_PC 5'h08
`define BTFB_REG_BANK 5'h0c
`define BTFB_REG_INDEX 5'h10
`define BTFB_REG_RETIRE 5'h14

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define BTFB_CTRL_RUN_BIT 0
`define BTFB_CTRL_EXT_BIT 1
`define BTFB_ST_UNSUP_BIT 2
`define BTFB_CTRL_RST 2'h0
`define BTFB_BANK_RST 4'h0
`define BTFB_INDEX_RST 12'h000
`define BTFB_RETIRE_RST 16'h0000

`endif

// ---- rtl/btfb_pkg.sv ----
// types shared by the bit-toggle and flag-branch execution block
`default_nettype none

package btfb_pkg;

  // ----------------------------------------------------------------
  // instruction cycle phases
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    btfb_q1 = 4'b0001,
    btfb_q2 = 4'b0010,
    btfb_q3 = 4'b0100,
    btfb_q4 = 4'b1000
  } btfb_phase_t;

  // ----------------------------------------------------------------
  // decoded operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    btfb_op_none = 4'b0001,
    btfb_op_toggle = 4'b0010,
    btfb_op_bov = 4'b0100,
    btfb_op_bz = 4'b1000
  } btfb_op_t;

endpackage

`default_nettype wire

// ---- rtl/btfb_phase_gen.sv ----
// four-phase instruction cycle sequencer
`default_nettype none

module btfb_phase_gen import btfb_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // current phase
  output btfb_phase_t phase
);

  btfb_phase_t phase_q;
  btfb_phase_t phase_d;

  always_comb begin
    case (phase_q)
      btfb_q1: phase_d = btfb_q2;
      btfb_q2: phase_d = btfb_q3;
      btfb_q3: phase_d = btfb_q4;
      btfb_q4: phase_d = btfb_q1;
      default: phase_d = btfb_q1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_q <= btfb_q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase = phase_q;

endmodule

`default_nettype wire

// ---- testbench/btfb_core_model.sv ----
// program and data memory standing around the execution unit
`default_nettype none

module btfb_core_model (
  // clock
  input wire logic clk_sys,
  // fetch side
  input wire logic [20:0] fetch_addr,
  output logic [15:0] instr_word,
  output logic instr_valid,
  // data side
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] imem [512];
  logic [7:0] dmem [4096];
  // empty slots hold 16'hffff and are offered as not valid
  assign instr_word = imem[fetch_addr[9:1]];
  assign instr_valid = instr_word != 16'hffff;
  always @(posedge clk_sys) begin
    // read data last one clock, then the bus shows garbage
    mem_rdata <= mem_rd ? dmem[mem_addr] : ~mem_rdata;
    if (mem_wr) begin
      dmem[mem_addr] <= mem_wdata;
    end
  end
endmodule

`default_nettype wire

// ---- testbench/btfb_exec_chk.sv ----
// assertions on the fetch and data memory ports of the unit
`default_nettype none

module btfb_exec_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // fetch path and flags
  input wire logic [20:0] fetch_addr,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic ovf_flag,
  input wire logic zero_flag,
  // data memory
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic acc;
  logic [2:0] bsel_q, bsel_d;
  logic [20:0] tgt_q, tgt_d, seq_q, seq_d;
  assign acc = instr_ready && instr_valid;
  // ----------------------------------------------------------------
  // operands captured at accept, held until the next accept
  // ----------------------------------------------------------------
  always_comb begin
    bsel_d = acc ? instr_word[3:1] : bsel_q;
    seq_d = acc ? fetch_addr + 21'h000002 : seq_q;
    tgt_d = acc ? seq_d + {{12{instr_word[7]}}, instr_word[7:0], 1'b0} : tgt_q;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bsel_q <= 3'h0;
      seq_q <= 21'h000000;
      tgt_q <= 21'h000000;
    end else begin
      bsel_q <= bsel_d;
      seq_q <= seq_d;
      tgt_q <= tgt_d;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_tog;
    acc && instr_word[15:12] == 4'h7;
  endsequence
  sequence s_br;
    acc && (instr_word[15:8] == 8'he4 || instr_word[15:8] == 8'he0);
  endsequence
  sequence s_jump;
    (acc && instr_word[15:8] == 8'he4 ##2 ovf_flag) or
    (acc && instr_word[15:8] == 8'he0 ##2 zero_flag);
  endsequence
  sequence s_stay;
    (acc && instr_word[15:8] == 8'he4 ##2 !ovf_flag) or
    (acc && instr_word[15:8] == 8'he0 ##2 !zero_flag);
  endsequence
  chk_tog_phase: assert property (s_tog |=> mem_rd ##1 !mem_rd ##1 mem_wr)
    else $error("toggle memory access out of phase");
  chk_tog_data: assert property (s_tog |-> ##3 mem_wdata == ($past(mem_rdata) ^ (8'h01 << bsel_q)))
    else $error("toggle wrote wrong byte");
  chk_tog_place: assert property (s_tog ##1 mem_rd |-> ##2 mem_wr && mem_addr == $past(mem_addr, 2))
    else $error("toggle wrote another address");
  chk_br_nomem: assert property (s_br |-> (!mem_rd && !mem_wr) [*4])
    else $error("branch touched data memory");
  chk_step_word: assert property (acc |=> fetch_addr == seq_q)
    else $error("fetch did not step one word");
  chk_jump_target: assert property (s_jump |-> ##2 fetch_addr == tgt_q)
    else $error("taken branch target wrong");
  chk_jump_idle: assert property (s_jump |-> ##2 (!instr_ready) [*4] ##1 instr_ready)
    else $error("taken branch idle cycle wrong");
  chk_stay_next: assert property (s_stay |-> ##2 instr_ready && fetch_addr == seq_q)
    else $error("untaken branch did not fall through");
endmodule

bind btfb_exec btfb_exec_chk btfb_exec_chk_inst (.clk_sys, .resetn, .fetch_addr, .instr_word,
  .instr_valid, .instr_ready, .ovf_flag, .zero_flag, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
  .mem_rdata);

`default_nettype wire

// ---- testbench/test_bit_toggle_and_flag_branch_exec.sv ----
// self-checking bench for the bit-toggle and flag-branch unit
`default_nettype none
`include "btfb_defs.svh"

module test_bit_toggle_and_flag_branch_exec;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, instr_valid, instr_ready, mem_rd, mem_wr;
  logic ovf_flag = 1'b0;
  logic zero_flag = 1'b0;
  logic [20:0] fetch_addr;
  logic [15:0] instr_word;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  btfb_exec btfb_exec_inst (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .fetch_addr,
    .instr_word, .instr_valid, .instr_ready, .ovf_flag, .zero_flag, .mem_addr, .mem_rd,
    .mem_wr, .mem_wdata, .mem_rdata);
  btfb_core_model model (.clk_sys, .fetch_addr, .instr_word, .instr_valid, .mem_addr,
    .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);

  always #12.5 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // hang guard, well above the few hundred cycles the tests need
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      finish_test();
    end
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge; data taken at that edge
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task run(input logic ext, input logic [20:0] pc, input int n);
    logic [31:0] q;
    bus(1'b1, `BTFB_REG_PC, {11'h0, pc}, q);
    bus(1'b1, `BTFB_REG_CTRL, {30'h0, ext, 1'b1}, q);
    repeat (n) @(posedge clk_sys);
    bus(1'b1, `BTFB_REG_CTRL, {30'h0, ext, 1'b0}, q);
  endtask

  task test_toggle;
    logic [31:0] q;
    logic [7:0] f [6] = '{8'h12, 8'h80, 8'h34, 8'h5f, 8'h60, 8'h12};
    logic [5:0] a = 6'h24;
    logic [11:0] ea [6] = '{12'h012, 12'hf80, 12'h534, 12'h25f, 12'hf60, 12'h512};
    bus(1'b1, `BTFB_REG_BANK, 32'h5, q);
    bus(1'b1, `BTFB_REG_INDEX, 32'h200, q);
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 3; k++) begin
        model.dmem[ea[3*r+k]] = 8'h75;
        model.imem[k] = {4'h7, f[3*r+k], 3'(3*(3*r+k)), a[3*r+k]};
      end
      run(r[0], 21'h0, 20);
    end
    for (int i = 0; i < 6; i++) begin
      check("toggled byte", 32'(model.dmem[ea[i]]), 32'(8'h75 ^ (8'h01 << 3'(3*i))));
    end
    for (int k = 0; k < 3; k++) begin
      model.imem[k] = 16'hffff;
    end
  endtask

  task test_branch;
    logic [31:0] q;
    logic [5:0] isbov = 6'h13;
    logic [5:0] ovf = 6'h19;
    logic [5:0] zero = 6'h16;
    logic [7:0] n [6] = '{8'h80, 8'h7f, 8'h7f, 8'h80, 8'h05, 8'h05};
    logic tk;
    logic [20:0] e;
    for (int i = 0; i < 6; i++) begin
      ovf_flag <= ovf[i];
      zero_flag <= zero[i];
      model.imem[9'h080] = {isbov[i] ? 8'he4 : 8'he0, n[i]};
      tk = isbov[i] ? ovf[i] : zero[i];
      run(1'b0, 21'h100, 16);
      bus(1'b0, `BTFB_REG_PC, 32'h0, q);
      // pc wraps at 21 bits, so the sum is formed at that width
      e = tk ? 21'h102 + {{12{n[i][7]}}, n[i], 1'b0} : 21'h102;
      check("branch pc", q, {11'h0, e});
      bus(1'b0, `BTFB_REG_STATUS, 32'h0, q);
      check("branch taken flag", q, {30'h0, tk, 1'b0});
    end
    bus(1'b0, 5'h1c, 32'h0, q);
    check("unmapped read", q, 32'h0);
  endtask

  task test_status;
    logic [31:0] q;
    model.imem[9'h080] = 16'h1234;
    run(1'b0, 21'h100, 8);
    bus(1'b0, `BTFB_REG_STATUS, 32'h0, q);
    check("unsupported flag", q, 32'h4);
    bus(1'b0, `BTFB_REG_PC, 32'h0, q);
    check("unsupported pc", q, 32'h102);
    bus(1'b1, `BTFB_REG_STATUS, 32'h4, q);
    bus(1'b0, `BTFB_REG_STATUS, 32'h0, q);
    check("flag cleared", q, 32'h0);
    bus(1'b0, `BTFB_REG_RETIRE, 32'h0, q);
    check("retired count", q, 32'hd);
    avs_byteenable <= 4'h0;
    bus(1'b1, `BTFB_REG_BANK, 32'ha, q);
    avs_byteenable <= 4'hf;
    bus(1'b0, `BTFB_REG_BANK, 32'h0, q);
    check("masked bank write", q, 32'h5);
  endtask

  task finish_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 512; i++) begin
      model.imem[i] = 16'hffff;
    end
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    test_toggle();
    test_branch();
    test_status();
    finish_test();
  end
endmodule

`default_nettype wire
